// File: logic/tbf_pkg.sv
// Constants, types and coding functions for the tape block trailer formatter
package tbf_pkg;

  // Block geometry
  localparam int unsigned BLK_BYTES     = 512;
  localparam int unsigned ADDR_BYTES    = 4;
  localparam logic [15:0] BLK_NUM_FIRST = 16'h0001;

  // Control nibble values (others reserved)
  localparam logic [3:0]  CTL_DATA      = 4'h0;
  localparam logic [3:0]  CTL_FORMAT    = 4'h2;

  // Check value and block marker
  localparam logic [15:0] CRC_INIT      = 16'hFFFF;
  localparam logic [15:0] CRC_POLY      = 16'h1021;
  localparam logic [4:0]  MARK_GROUP    = 5'h1F;

  // Preamble and postamble lengths in flux transitions, each inside its band
  localparam int unsigned PRE_NORM_9    = 200;
  localparam int unsigned PRE_NORM_X    = 200;
  localparam int unsigned PRE_ELONG_9   = 5000;
  localparam int unsigned PRE_ELONG_X   = 6000;
  localparam int unsigned PRE_LONG      = 20000;
  localparam int unsigned POST_NORM     = 10;
  localparam int unsigned POST_ELONG_9  = 5000;
  localparam int unsigned POST_ELONG_X  = 7000;

  // Recording formats
  typedef enum logic [1:0] {
    FMT_9TRK  = 2'h0,
    FMT_15TRK = 2'h1,
    FMT_18TRK = 2'h2
  } tbf_fmt_e;

  // Framing states
  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_PRE  = 7'b000_0010,
    ST_MARK = 7'b000_0100,
    ST_DATA = 7'b000_1000,
    ST_ADDR = 7'b001_0000,
    ST_CRC  = 7'b010_0000,
    ST_POST = 7'b100_0000
  } tbf_state_e;

  // Per-block request from the controller
  typedef struct packed {
    tbf_fmt_e   fmt;
    logic       underrun;
    logic       trk_start;
    logic       ctl_blk;
    logic [7:0] trk_num;
  } tbf_req_s;

  // One symbol towards the write channel
  typedef struct packed {
    logic       valid;
    logic       flux;
    logic [4:0] group;
  } tbf_sym_s;

  // Nibble to 5-bit group code
  function automatic logic [4:0] tbf_gcr(input logic [3:0] nib);
    logic [4:0] g;
    g = 5'h00;
    case (nib)
      4'h0: g = 5'h19;
      4'h1: g = 5'h1B;
      4'h2: g = 5'h12;
      4'h3: g = 5'h13;
      4'h4: g = 5'h1D;
      4'h5: g = 5'h15;
      4'h6: g = 5'h16;
      4'h7: g = 5'h17;
      4'h8: g = 5'h1A;
      4'h9: g = 5'h09;
      4'hA: g = 5'h0A;
      4'hB: g = 5'h0B;
      4'hC: g = 5'h1E;
      4'hD: g = 5'h0D;
      4'hE: g = 5'h0E;
      default: g = 5'h0F;
    endcase
    return g;
  endfunction

  // One byte into the check register, msb first
  function automatic logic [15:0] tbf_crc_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ d[i]) begin
        c = {c[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

endpackage

// File: logic/tbf_formatter.sv
// Tape block framer: preamble, marker, data, block address, check bytes, postamble
module tbf_formatter
  import tbf_pkg::*;
#(
  parameter int unsigned BLK_LEN   = BLK_BYTES,
  parameter int unsigned PRE_LONG_N  = PRE_LONG,
  parameter int unsigned PRE_EL9_N   = PRE_ELONG_9,
  parameter int unsigned PRE_ELX_N   = PRE_ELONG_X,
  parameter int unsigned POST_EL9_N  = POST_ELONG_9,
  parameter int unsigned POST_ELX_N  = POST_ELONG_X
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  // Controller side
  input  wire logic       start_in,
  input  wire tbf_req_s   req_in,
  input  wire logic       track_end_in,
  output logic            busy_out,
  // Data buffer side
  input  wire logic [7:0] data_in,
  input  wire logic       data_valid_in,
  output logic            data_ready_out,
  // Write channel side
  output tbf_sym_s        sym_out
);

  tbf_state_e  state_r, state_nxt;
  tbf_req_s    req_r,   req_nxt;
  logic [15:0] cnt_r,   cnt_nxt;
  logic [9:0]  idx_r,   idx_nxt;
  logic        phase_r, phase_nxt;
  logic [7:0]  byte_r,  byte_nxt;
  logic [15:0] crc_r,   crc_nxt;
  logic [15:0] blk_r,   blk_nxt;
  tbf_sym_s    sym_nxt;
  logic        rdy_nxt;
  logic        busy_nxt;
  logic [7:0]  addr_byte;
  logic [3:0]  ctl_nib;

  // Control nibble: only the two legal block types can be produced
  // block type
  assign ctl_nib = req_r.ctl_blk ? CTL_FORMAT : CTL_DATA;

  // Block address bytes: track, control, block number high, low
  // address layout
  always_comb begin
    case (idx_r[1:0])
      2'd0:    addr_byte = req_r.trk_num;
      2'd1:    addr_byte = {4'h0, ctl_nib};
      2'd2:    addr_byte = blk_r[15:8];
      default: addr_byte = blk_r[7:0];
    endcase
  end

  // Length of the preamble for a new request; long beats elongated beats normal
  function automatic logic [15:0] pre_len(input tbf_req_s r);
    logic [15:0] n;
    n = 16'(PRE_NORM_X);
    if (r.trk_start) begin
      n = 16'(PRE_LONG_N);
    end else if (r.underrun) begin
      n = (r.fmt == FMT_9TRK) ? 16'(PRE_EL9_N) : 16'(PRE_ELX_N);
    end else if (r.fmt == FMT_9TRK) begin
      n = 16'(PRE_NORM_9);
    end
    return n;
  endfunction

  // Length of the postamble for the block in flight
  function automatic logic [15:0] post_len(input tbf_req_s r);
    logic [15:0] n;
    n = 16'(POST_NORM);
    if (r.underrun && !r.ctl_blk) begin
      n = (r.fmt == FMT_9TRK) ? 16'(POST_EL9_N) : 16'(POST_ELX_N);
    end
    return n;
  endfunction

  // Framing sequencer next state
  always_comb begin
    state_nxt = state_r;
    req_nxt   = req_r;
    cnt_nxt   = cnt_r;
    idx_nxt   = idx_r;
    phase_nxt = phase_r;
    byte_nxt  = byte_r;
    crc_nxt   = crc_r;
    blk_nxt   = blk_r;
    sym_nxt   = '0;
    case (state_r)
      ST_IDLE: begin
        if (start_in) begin
          req_nxt   = req_in;
          cnt_nxt   = pre_len(req_in);
          crc_nxt   = CRC_INIT;
          state_nxt = ST_PRE;
        end
      end
      ST_PRE: begin
        sym_nxt = '{valid: 1'b1, flux: 1'b1, group: 5'h00};
        cnt_nxt = cnt_r - 16'd1;
        if (cnt_r == 16'd1) begin
          state_nxt = ST_MARK;
        end
      end
      ST_MARK: begin
        sym_nxt   = '{valid: 1'b1, flux: 1'b0, group: MARK_GROUP};
        idx_nxt   = '0;
        phase_nxt = 1'b0;
        state_nxt = ST_DATA;
      end
      ST_DATA: begin
        if (!phase_r) begin
          if (data_ready_out && data_valid_in) begin
            sym_nxt   = '{valid: 1'b1, flux: 1'b0, group: tbf_gcr(data_in[7:4])};
            byte_nxt  = data_in;
            crc_nxt   = tbf_crc_byte(crc_r, data_in);
            phase_nxt = 1'b1;
          end
        end else begin
          sym_nxt   = '{valid: 1'b1, flux: 1'b0, group: tbf_gcr(byte_r[3:0])};
          phase_nxt = 1'b0;
          idx_nxt   = idx_r + 10'd1;
          if (idx_r == 10'(BLK_LEN - 1)) begin
            idx_nxt   = '0;
            state_nxt = ST_ADDR;
          end
        end
      end
      ST_ADDR: begin
        if (!phase_r) begin
          sym_nxt   = '{valid: 1'b1, flux: 1'b0, group: tbf_gcr(addr_byte[7:4])};
          byte_nxt  = addr_byte;
          crc_nxt   = tbf_crc_byte(crc_r, addr_byte);
          phase_nxt = 1'b1;
        end else begin
          sym_nxt   = '{valid: 1'b1, flux: 1'b0, group: tbf_gcr(byte_r[3:0])};
          phase_nxt = 1'b0;
          idx_nxt   = idx_r + 10'd1;
          if (idx_r == 10'(ADDR_BYTES - 1)) begin
            idx_nxt   = '0;
            state_nxt = ST_CRC;
          end
        end
      end
      ST_CRC: begin
        if (!phase_r) begin
          byte_nxt  = idx_r[0] ? crc_r[7:0] : crc_r[15:8];
          sym_nxt   = '{valid: 1'b1, flux: 1'b0, group: tbf_gcr(byte_nxt[7:4])};
          phase_nxt = 1'b1;
        end else begin
          sym_nxt   = '{valid: 1'b1, flux: 1'b0, group: tbf_gcr(byte_r[3:0])};
          phase_nxt = 1'b0;
          idx_nxt   = idx_r + 10'd1;
          if (idx_r[0]) begin
            cnt_nxt   = post_len(req_r);
            state_nxt = ST_POST;
          end
        end
      end
      ST_POST: begin
        sym_nxt = '{valid: 1'b1, flux: 1'b1, group: 5'h00};
        cnt_nxt = cnt_r - 16'd1;
        if (cnt_r == 16'd1) begin
          blk_nxt   = blk_r + 16'd1;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // track end restarts numbering; wins over the increment
    if (track_end_in) begin
      blk_nxt = BLK_NUM_FIRST;
    end
    // Ready registered, so the byte is offered only in the nibble-high slot
    rdy_nxt  = (state_nxt == ST_DATA) && !phase_nxt;
    busy_nxt = (state_nxt != ST_IDLE);
  end

  // Framing sequencer registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r        <= ST_IDLE;
      req_r          <= '0;
      cnt_r          <= '0;
      idx_r          <= '0;
      phase_r        <= 1'b0;
      byte_r         <= '0;
      crc_r          <= CRC_INIT;
      blk_r          <= BLK_NUM_FIRST;
      sym_out        <= '0;
      data_ready_out <= 1'b0;
      busy_out       <= 1'b0;
    end else begin
      state_r        <= state_nxt;
      req_r          <= req_nxt;
      cnt_r          <= cnt_nxt;
      idx_r          <= idx_nxt;
      phase_r        <= phase_nxt;
      byte_r         <= byte_nxt;
      crc_r          <= crc_nxt;
      blk_r          <= blk_nxt;
      sym_out        <= sym_nxt;
      data_ready_out <= rdy_nxt;
      busy_out       <= busy_nxt;
    end
  end

  chk_crc_preset: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_r == ST_MARK) |-> (crc_r == CRC_INIT))
    else $error("check register not preset at block marker");

  chk_mark_group: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_r == ST_MARK) |=> (sym_out.valid && !sym_out.flux && sym_out.group == MARK_GROUP))
    else $error("block marker group wrong");

  chk_blk_restart: assert property (@(posedge clk_in) disable iff (!nrst_in)
    track_end_in |=> (blk_r == BLK_NUM_FIRST))
    else $error("block number not restarted at track end");

  chk_blk_incr: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_r == ST_POST && cnt_r == 16'd1 && !track_end_in) |=> (blk_r == $past(blk_r) + 16'd1))
    else $error("block number did not step by one");

  chk_addr_track: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_r == ST_ADDR && idx_r == 10'd0 && !phase_r)
      |=> (sym_out.group == tbf_gcr(req_r.trk_num[7:4])) ##1
          (sym_out.group == tbf_gcr(req_r.trk_num[3:0])))
    else $error("track number not first in block address");

  chk_ctl_nibble: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_r == ST_ADDR && idx_r == 10'd1 && !phase_r)
      |=> (sym_out.group == tbf_gcr(4'h0)) ##1
          (sym_out.group == (req_r.ctl_blk ? tbf_gcr(CTL_FORMAT) : tbf_gcr(CTL_DATA))))
    else $error("control nibble wrong");

  chk_crc_order: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_r == ST_CRC && idx_r == 10'd0 && !phase_r)
      |=> (sym_out.group == tbf_gcr($past(crc_r[15:12]))))
    else $error("check high nibble not sent first");

  // data accepted only at nibble-high slot
  chk_ready_slot: assert property (@(posedge clk_in) disable iff (!nrst_in)
    data_ready_out |-> (state_r == ST_DATA && !phase_r))
    else $error("data ready outside a byte slot");

  chk_post_len: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_r == ST_CRC && idx_r[0] && phase_r) |=> (cnt_r == post_len(req_r)))
    else $error("postamble length wrong");

  chk_pre_long: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_r == ST_IDLE && start_in && req_in.trk_start) |=> (cnt_r == 16'(PRE_LONG_N)))
    else $error("long preamble not chosen");

endmodule

// File: sim/tbf_chan_model.sv
// Write channel model: measures flux runs and collects coded groups
module tbf_chan_model
  import tbf_pkg::*;
(
  // Clock and reset
  input  wire logic   clk_in,
  input  wire logic   nrst_in,
  // Symbols from the formatter
  input  wire tbf_sym_s sym_in,
  // Decoded events
  output logic        run_v_out,
  output logic [15:0] run_len_out,
  output logic        grp_v_out,
  output logic [4:0]  grp_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] cnt_r;

  // A run closes on the first cycle without flux; the head never pushes back
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r       <= 16'h0000;
      run_v_out   <= 1'b0;
      run_len_out <= 16'h0000;
      grp_v_out   <= 1'b0;
      grp_out     <= 5'h00;
    end else if (sym_in.valid && sym_in.flux) begin
      cnt_r     <= cnt_r + 16'h0001;
      run_v_out <= 1'b0;
      grp_v_out <= 1'b0;
    end else begin
      cnt_r       <= 16'h0000;
      run_v_out   <= (cnt_r != 16'h0000);
      run_len_out <= cnt_r;
      grp_v_out   <= sym_in.valid;
      grp_out     <= sym_in.group;
    end
  end
endmodule

// File: sim/tbf_formatter_tb.sv
// Self-checking bench for the tape block trailer formatter
module tbf_formatter_tb
  import tbf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Shortened counts so the run stays brief
  localparam int unsigned BL = 4;
  localparam int unsigned PL = 20;
  localparam int unsigned E9 = 8;
  localparam int unsigned EX = 9;
  localparam int unsigned Q9 = 6;
  localparam int unsigned QX = 7;
  localparam logic [4:0] GC [16] = '{5'h19, 5'h1B, 5'h12, 5'h13, 5'h1D, 5'h15, 5'h16, 5'h17,
                                     5'h1A, 5'h09, 5'h0A, 5'h0B, 5'h1E, 5'h0D, 5'h0E, 5'h0F};

  logic        clk_in        = 1'b0;
  logic        nrst_in       = 1'b0;
  logic        start_in      = 1'b0;
  logic        track_end_in  = 1'b0;
  logic        data_valid_in = 1'b0;
  logic [7:0]  data_in       = 8'h00;
  tbf_req_s    req_in        = '0;
  logic        busy_out;
  logic        data_ready_out;
  tbf_sym_s    sym_out;
  logic        run_v;
  logic [15:0] run_len;
  logic        grp_v;
  logic [4:0]  grp;
  int          bad_count     = 0;
  int          compares      = 0;
  logic [31:0] exp_q [$];
  logic [15:0] bn            = 16'h0001;

  tbf_formatter #(.BLK_LEN(BL), .PRE_LONG_N(PL), .PRE_EL9_N(E9), .PRE_ELX_N(EX),
                  .POST_EL9_N(Q9), .POST_ELX_N(QX)) uut (
    .clk_in(clk_in), .nrst_in(nrst_in), .start_in(start_in), .req_in(req_in),
    .track_end_in(track_end_in), .busy_out(busy_out), .data_in(data_in),
    .data_valid_in(data_valid_in), .data_ready_out(data_ready_out), .sym_out(sym_out));

  tbf_chan_model chan (.clk_in(clk_in), .nrst_in(nrst_in), .sym_in(sym_out),
    .run_v_out(run_v), .run_len_out(run_len), .grp_v_out(grp_v), .grp_out(grp));

  // 200 MHz clock
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic end_sim();
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bitwise check update, msb first, no final inversion
  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction

  // High nibble group first, then low
  task automatic push_byte(inout logic [15:0] c, input logic [7:0] b);
    exp_q.push_back({27'h0, GC[b[7:4]]});
    exp_q.push_back({27'h0, GC[b[3:0]]});
    c = crc8(c, b);
  endtask

  // Notes the whole expected block, then drives it with random stalls
  task automatic run_block(input tbf_req_s r, input bit poke);
    logic [7:0]  d [BL];
    logic [15:0] c;
    logic [15:0] f;
    int unsigned pre;
    int unsigned post;
    int unsigned n;
    c = CRC_INIT;
    pre = r.trk_start ? PL : r.underrun ? (r.fmt == FMT_9TRK ? E9 : EX) :
          (r.fmt == FMT_9TRK ? PRE_NORM_9 : PRE_NORM_X);
    post = (r.underrun && !r.ctl_blk) ? (r.fmt == FMT_9TRK ? Q9 : QX) : POST_NORM;
    exp_q.push_back(32'h8000_0000 | pre);
    exp_q.push_back({27'h0, MARK_GROUP});
    for (int k = 0; k < BL; k++) begin
      d[k] = 8'($urandom);
      push_byte(c, d[k]);
    end
    push_byte(c, r.trk_num);
    push_byte(c, {4'h0, r.ctl_blk ? CTL_FORMAT : CTL_DATA});
    push_byte(c, bn[15:8]);
    push_byte(c, bn[7:0]);
    f = c;
    push_byte(c, f[15:8]);
    push_byte(c, f[7:0]);
    exp_q.push_back(32'h8000_0000 | post);
    bn = bn + 16'h0001;
    while (busy_out !== 1'b0) begin
      @(posedge clk_in);
      #1;
    end
    start_in = 1'b1;
    req_in = r;
    @(posedge clk_in);
    #1;
    start_in = 1'b0;
    chk({31'h0, busy_out}, 32'h1);
    // A second start while busy, with other settings, must change nothing
    if (poke) begin
      @(posedge clk_in);
      #1;
      start_in = 1'b1;
      req_in.trk_num = ~r.trk_num;
      req_in.ctl_blk = ~r.ctl_blk;
      @(posedge clk_in);
      #1;
      start_in = 1'b0;
    end
    for (int k = 0; k < BL; k++) begin
      n = $urandom % 3;
      if (n != 0) begin
        data_valid_in = 1'b0;
        repeat (n) @(posedge clk_in);
        #1;
      end
      data_in = d[k];
      data_valid_in = 1'b1;
      // Ready read between edges, where it is settled, then held through the taking edge
      while (data_ready_out !== 1'b1) begin
        @(posedge clk_in);
        #1;
      end
      @(posedge clk_in);
      #1;
    end
    data_valid_in = 1'b0;
  endtask

  // Takes the oldest note whenever the channel model reports something
  always @(posedge clk_in) begin
    if (run_v) begin
      chk({16'h8000, run_len}, exp_q.size() ? exp_q.pop_front() : 32'hFFFF_FFFF);
    end
    if (grp_v) begin
      chk({27'h0, grp}, exp_q.size() ? exp_q.pop_front() : 32'hFFFF_FFFF);
    end
  end

  // Main sequence: formats, preamble kinds, block kinds and a track change
  initial begin
    tbf_req_s r;
    void'($urandom(32'hf73b_a640));
    repeat (20) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i == 5) begin
        // Track ends only once the block in flight has left, its address already sent
        while (busy_out !== 1'b0) begin
          @(posedge clk_in);
          #1;
        end
        track_end_in = 1'b1;
        @(posedge clk_in);
        #1;
        track_end_in = 1'b0;
        bn = 16'h0001;
      end
      r.fmt = tbf_fmt_e'(i % 3);
      r.trk_start = (i == 0) || (i == 5);
      r.underrun = (i == 2) || (i == 6) || (i == 7);
      r.ctl_blk = (i == 3) || (i == 7);
      r.trk_num = 8'($urandom);
      run_block(r, i == 4);
    end
    do repeat (4) @(posedge clk_in); while (busy_out !== 1'b0 || exp_q.size() != 0);
    end_sim();
  end

  // Watchdog, well beyond the expected thousand or so cycles
  initial begin
    #100000;
    bad_count++;
    end_sim();
  end
endmodule
